// ===== hw/ilc_defines.svh
// register offsets, field positions, reset values and timing for the inband loop code unit
// assumes a plain 5-bit register port, 8-bit data, one 200 MHz clock
`ifndef ILC_DEFINES_SVH
`define ILC_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ILC_OFS_CONFIG       5'h08
`define ILC_OFS_ACT_PAT      5'h09
`define ILC_OFS_DEACT_PAT    5'h0A
`define ILC_OFS_STATUS       5'h0B
`define ILC_OFS_MASK         5'h0C
`define ILC_OFS_FLAG         5'h0D
`define ILC_OFS_GEN_SEL      5'h0E
`define ILC_OFS_GEN_EN       5'h0F

// ****************************************************************
// fields and reset values
// ****************************************************************
`define ILC_CFG_WMASK        8'h3F
`define ILC_GEN_SEL_BIT      0
`define ILC_RST_BYTE         8'h00
`define ILC_NCH              8
`define ILC_MIN_LEN          5

// ****************************************************************
// timing
// ****************************************************************
`define ILC_CLK_MHZ          200
`define ILC_QUAL_TIME_MS     5100
`define ILC_QUAL_CYCLES      (`ILC_QUAL_TIME_MS * 1000 * `ILC_CLK_MHZ)
`define ILC_CNT_W            30

`endif

// ===== hw/ilc_pkg.sv
// types shared by the inband loop code unit
// assumes ilc_defines.svh is on the include path
`include "ilc_defines.svh"

package ilc_pkg;

  // configuration byte layout, msb first
  typedef struct packed {
    logic [1:0] rsvd;
    logic       detect_enable;
    logic       auto_loop_enable;
    logic [1:0] deactivate_length;
    logic [1:0] activate_length;
  } ilc_cfg_t;

  // per-channel detector state
  typedef struct packed {
    logic [7:0]            sr;
    logic [3:0]            fill;
    logic                  run;
    logic                  kind_act;
    logic [`ILC_CNT_W-1:0] cnt;
    logic                  present;
    logic                  loop;
  } ilc_chan_st_t;

  // top-level state
  typedef struct packed {
    ilc_cfg_t                     cfg;
    logic [7:0]                   act_pat;
    logic [7:0]                   deact_pat;
    logic [7:0]                   gen_sel;
    logic [7:0]                   gen_en;
    logic [7:0]                   mask;
    logic [7:0]                   flag;
    logic [7:0]                   prev_present;
    logic [7:0]                   rdata;
    logic                         irq;
    logic [`ILC_NCH-1:0]          rxd_s1;
    logic [`ILC_NCH-1:0]          rxd_s2;
    logic [`ILC_NCH-1:0]          rxc_s1;
    logic [`ILC_NCH-1:0]          rxc_s2;
    logic [`ILC_NCH-1:0]          rxc_s3;
    logic [`ILC_NCH-1:0]          txd_s1;
    logic [`ILC_NCH-1:0]          txd_s2;
    logic [`ILC_NCH-1:0]          txc_s1;
    logic [`ILC_NCH-1:0]          txc_s2;
    logic [`ILC_NCH-1:0]          txc_s3;
    logic [`ILC_NCH-1:0][2:0]     gen_idx;
    logic [`ILC_NCH-1:0]          line_tx_data;
    logic [`ILC_NCH-1:0]          line_tx_clk;
  } ilc_top_st_t;

endpackage : ilc_pkg

// ===== hw/ilc_chan.sv
// one channel of the loop code detector: pattern match, qualification timer, loopback state
// assumes bit_stb is a one-cycle strobe in ref_clk domain marking a new received bit
`timescale 1ns/1ps
`include "ilc_defines.svh"

module ilc_chan #(
  parameter int unsigned QUAL_CYCLES = `ILC_QUAL_CYCLES
) (
  input  wire logic       ref_clk,            // device clock
  input  wire logic       rst_n,              // async reset, active low
  input  wire logic       bit_stb,            // new received bit valid
  input  wire logic       bit_val,            // received bit
  input  wire ilc_pkg::ilc_cfg_t cfg,         // shared configuration
  input  wire logic [7:0] act_pat,            // activate pattern
  input  wire logic [7:0] deact_pat,          // deactivate pattern
  output logic            present,            // a loop code is present
  output logic            loop_active         // auto remote loopback state
);
  import ilc_pkg::*;

  ilc_chan_st_t s;
  ilc_chan_st_t next_s;
  logic         hit_a;
  logic         hit_d;

  // true when win equals some rotation of the code held in the top ILC_MIN_LEN + len bits of pat
  function automatic logic rot_match(input logic [7:0] pat, input logic [1:0] len, input logic [7:0] win);
    int         l;
    logic [7:0] exp_w;
    logic       m;
    l = `ILC_MIN_LEN + int'(len);
    m = 1'b0;
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 8; i++) begin
        exp_w[7-i] = pat[7 - ((k + i) % l)];
      end
      if (k < l && exp_w == win) begin
        m = 1'b1;
      end
    end
    return m;
  endfunction : rot_match

  // matching on a full 8-bit window keeps a short burst of noise from looking like a code
  always_comb begin
    next_s = s;
    hit_a  = (s.fill == 4'h8) && rot_match(act_pat, cfg.activate_length, s.sr);
    hit_d  = (s.fill == 4'h8) && rot_match(deact_pat, cfg.deactivate_length, s.sr);
    if (!cfg.detect_enable) begin
      next_s.fill    = 4'h0;
      next_s.run     = 1'b0;
      next_s.cnt     = '0;
      next_s.present = 1'b0;
    end else begin
      if (bit_stb) begin
        next_s.sr = {s.sr[6:0], bit_val};
        if (s.fill != 4'h8) begin
          next_s.fill = s.fill + 4'h1;
        end
      end
      next_s.present = hit_a | hit_d;
      // the timer restarts on any mismatch or change of code kind
      if (hit_a || hit_d) begin
        if (!s.run || s.kind_act != hit_a) begin
          next_s.run      = 1'b1;
          next_s.kind_act = hit_a;
          next_s.cnt      = '0;
        end else if (s.cnt != `ILC_CNT_W'(QUAL_CYCLES - 1)) begin
          next_s.cnt = s.cnt + `ILC_CNT_W'(1);
        end else if (cfg.auto_loop_enable) begin
          if (s.kind_act) begin
            next_s.loop = 1'b1;
          end else if (s.loop) begin
            next_s.loop = 1'b0;
          end
        end
      end else begin
        next_s.run = 1'b0;
        next_s.cnt = '0;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign present     = s.present;
  assign loop_active = s.loop;

endmodule : ilc_chan

// ===== hw/ilc_top.sv
// inband loop code unit: registers, eight detectors, generator and remote loopback path
// assumes the host bus logic drives the register port synchronously to ref_clk;
// line receive and transmit clocks and data arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`include "ilc_defines.svh"

module ilc_top #(
  parameter int unsigned QUAL_CYCLES = `ILC_QUAL_CYCLES
) (
  input  wire logic       ref_clk,            // 200 MHz device clock
  input  wire logic       rst_n,              // async reset, active low
  input  wire logic [4:0] reg_addr,           // register address
  input  wire logic [7:0] reg_wdata,          // write data
  input  wire logic       reg_wr,             // write strobe, one cycle
  input  wire logic       reg_rd,             // read strobe, one cycle
  output logic [7:0]      reg_rdata,          // read data, one cycle after reg_rd
  output logic            irq,                // interrupt, active high level
  input  wire logic [7:0] rx_clk,             // recovered receive clock per channel
  input  wire logic [7:0] rx_data,            // recovered receive data per channel
  input  wire logic [7:0] tx_clk,             // system transmit clock per channel
  input  wire logic [7:0] tx_data,            // system transmit data per channel
  input  wire logic [7:0] remote_loop_select, // manual remote loopback per channel
  output logic [7:0]      line_tx_clk,        // clock towards the line driver
  output logic [7:0]      line_tx_data,       // data towards the line driver
  output logic [7:0]      code_presence_status, // live presence per channel
  output logic [7:0]      remote_loop_active  // channel is in remote loopback
);
  import ilc_pkg::*;

  // ****************************************************************
  // state and channel wiring
  // ****************************************************************
  ilc_top_st_t s;
  ilc_top_st_t next_s;
  logic [7:0]  present;
  logic [7:0]  auto_loop;
  logic [7:0]  loop_on;
  logic [7:0]  rx_edge;
  logic [7:0]  tx_edge;
  logic [7:0]  clr;
  logic [7:0]  changed;
  logic [7:0]  gen_pat;
  logic [1:0]  gen_len;
  logic [2:0]  gen_last;
  logic [7:0]  loop_reg;

  // ****************************************************************
  // detectors, one per channel
  // ****************************************************************
  // every channel sees the same configuration and pattern registers, nothing per channel
  genvar g;
  generate
    for (g = 0; g < `ILC_NCH; g++) begin : g_chan
      ilc_chan #(
        .QUAL_CYCLES (QUAL_CYCLES)
      ) u_chan (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .bit_stb     (rx_edge[g]),
        .bit_val     (s.rxd_s2[g]),
        .cfg         (s.cfg),
        .act_pat     (s.act_pat),
        .deact_pat   (s.deact_pat),
        .present     (present[g]),
        .loop_active (auto_loop[g])
      );
    end
  endgenerate

  // ****************************************************************
  // derived terms
  // ****************************************************************
  // edges are taken only from second and third sync stages, never the first
  assign rx_edge  = s.rxc_s2 & ~s.rxc_s3;
  assign tx_edge  = s.txc_s2 & ~s.txc_s3;
  assign loop_on  = auto_loop | remote_loop_select;
  // generator shares the detector patterns and lengths; select picks which one
  assign gen_pat  = s.gen_sel[`ILC_GEN_SEL_BIT] ? s.deact_pat : s.act_pat;
  assign gen_len  = s.gen_sel[`ILC_GEN_SEL_BIT] ? s.cfg.deactivate_length : s.cfg.activate_length;
  assign gen_last = 3'(`ILC_MIN_LEN - 1) + 3'(gen_len);
  assign clr      = (reg_rd && reg_addr == `ILC_OFS_FLAG) ? 8'hFF : 8'h00;
  assign changed  = present ^ s.prev_present;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;

    // two-flop synchronisers for line data; line clocks get a third stage for edge detection
    next_s.rxd_s1 = rx_data;
    next_s.rxd_s2 = s.rxd_s1;
    next_s.rxc_s1 = rx_clk;
    next_s.rxc_s2 = s.rxc_s1;
    next_s.rxc_s3 = s.rxc_s2;
    next_s.txd_s1 = tx_data;
    next_s.txd_s2 = s.txd_s1;
    next_s.txc_s1 = tx_clk;
    next_s.txc_s2 = s.txc_s1;
    next_s.txc_s3 = s.txc_s2;

    // register writes; reserved configuration bits are not stored and read as zero
    if (reg_wr) begin
      unique case (reg_addr)
        `ILC_OFS_CONFIG:    next_s.cfg       = ilc_cfg_t'(reg_wdata & `ILC_CFG_WMASK);
        `ILC_OFS_ACT_PAT:   next_s.act_pat   = reg_wdata;
        `ILC_OFS_DEACT_PAT: next_s.deact_pat = reg_wdata;
        `ILC_OFS_MASK:      next_s.mask      = reg_wdata;
        `ILC_OFS_GEN_SEL:   next_s.gen_sel   = reg_wdata;
        `ILC_OFS_GEN_EN:    next_s.gen_en    = reg_wdata;
        default:            next_s.mask      = s.mask;
      endcase
    end

    // register reads; unmapped addresses return zero
    if (reg_rd) begin
      unique case (reg_addr)
        `ILC_OFS_CONFIG:    next_s.rdata = s.cfg;
        `ILC_OFS_ACT_PAT:   next_s.rdata = s.act_pat;
        `ILC_OFS_DEACT_PAT: next_s.rdata = s.deact_pat;
        `ILC_OFS_STATUS:    next_s.rdata = present;
        `ILC_OFS_MASK:      next_s.rdata = s.mask;
        `ILC_OFS_FLAG:      next_s.rdata = s.flag;
        `ILC_OFS_GEN_SEL:   next_s.rdata = s.gen_sel;
        `ILC_OFS_GEN_EN:    next_s.rdata = s.gen_en;
        default:            next_s.rdata = `ILC_RST_BYTE;
      endcase
    end

    // flags are sticky and clear on read; a change in the read cycle still sets its flag
    next_s.prev_present = present;
    next_s.flag         = (s.flag & ~clr) | changed;
    next_s.irq          = |(next_s.flag & s.mask);

    // transmit side, per channel
    for (int c = 0; c < `ILC_NCH; c++) begin
      if (loop_on[c]) begin
        // remote loopback: received clock and data go back out, transmit inputs ignored
        next_s.line_tx_clk[c]  = s.rxc_s2[c];
        next_s.line_tx_data[c] = s.rxd_s2[c];
        next_s.gen_idx[c]      = 3'h0;
      end else if (s.gen_en[c]) begin
        next_s.line_tx_clk[c] = s.txc_s2[c];
        // a new code bit is launched on each rising transmit clock
        if (tx_edge[c]) begin
          next_s.line_tx_data[c] = gen_pat[3'h7 - s.gen_idx[c]];
          next_s.gen_idx[c]      = (s.gen_idx[c] >= gen_last) ? 3'h0 : s.gen_idx[c] + 3'h1;
        end
      end else begin
        next_s.line_tx_clk[c]  = s.txc_s2[c];
        next_s.line_tx_data[c] = s.txd_s2[c];
        next_s.gen_idx[c]      = 3'h0;                       // restart code on re-enable
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // loop state registered so every output leaves a flip-flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_reg <= 8'h00;
    end else begin
      loop_reg <= loop_on;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // presence mirrors the detector flops directly, so status is never stale by more than one cycle
  assign reg_rdata            = s.rdata;
  assign irq                  = s.irq;
  assign line_tx_clk          = s.line_tx_clk;
  assign line_tx_data         = s.line_tx_data;
  assign code_presence_status = present;
  assign remote_loop_active   = loop_reg;

endmodule : ilc_top

// ===== verif/ilc_top_properties.sv
// port-level checker for the inband loop code unit top
// assumes it is bound into ilc_top and sees host writes on the register port
`timescale 1ns/1ps

module ilc_top_properties #(
  parameter int unsigned QUAL_CYCLES = 64
) (
  input wire logic       ref_clk,              // clock
  input wire logic       rst_n,                // reset
  input wire logic [4:0] reg_addr,             // address
  input wire logic [7:0] reg_wdata,            // write data
  input wire logic       reg_wr,               // write
  input wire logic       reg_rd,               // read
  input wire logic [7:0] reg_rdata,            // read data
  input wire logic       irq,                  // interrupt
  input wire logic [7:0] rx_clk,               // rx clock
  input wire logic [7:0] rx_data,              // rx data
  input wire logic [7:0] tx_clk,               // tx clock
  input wire logic [7:0] tx_data,              // tx data
  input wire logic [7:0] remote_loop_select,   // manual loop
  input wire logic [7:0] line_tx_clk,          // line clock
  input wire logic [7:0] line_tx_data,         // line data
  input wire logic [7:0] code_presence_status, // presence
  input wire logic [7:0] remote_loop_active    // loop state
);
  // ****************************************************************
  // shadows and run length
  // ****************************************************************
  logic [7:0]  cfg_sh;
  logic [7:0]  mask_sh;
  logic [31:0] run0;

  // saturating count so a long run never wraps into a short one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_sh  <= 8'h00;
      mask_sh <= 8'h00;
      run0    <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == 5'h08) cfg_sh <= reg_wdata;
      if (reg_wr && reg_addr == 5'h0C) mask_sh <= reg_wdata;
      if (!code_presence_status[0]) run0 <= 32'h00000000;
      else if (run0 != 32'hFFFFFFFF) run0 <= run0 + 32'h00000001;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_loop_enter_qual: assert property (
    $rose(remote_loop_active[0]) && !$past(remote_loop_select[0]) |-> run0 >= QUAL_CYCLES - 2)
    else $error("loop entered before the code qualified");
  a_loop_exit_qual: assert property (
    $fell(remote_loop_active[0]) && !$past(remote_loop_select[0]) && !$past(remote_loop_select[0], 2)
    |-> run0 >= QUAL_CYCLES - 2) else $error("loop left before the code qualified");
  a_detect_gated: assert property (
    (!cfg_sh[5]) [*3] |-> code_presence_status == 8'h00) else $error("presence with detection off");
  a_no_auto_enter: assert property (
    !cfg_sh[4] && !$past(cfg_sh[4]) && !$past(cfg_sh[4], 2) |-> (remote_loop_active & ~$past(remote_loop_active)
    & ~$past(remote_loop_select)) == 8'h00) else $error("automatic loop with auto off");
  a_irq_masked: assert property (
    (mask_sh == 8'h00) [*3] |-> !irq) else $error("interrupt with all masked");
  a_irq_cause: assert property (
    $rose(irq) |-> (mask_sh | $past(mask_sh)) != 8'h00) else $error("interrupt without mask");
  a_pat_readback: assert property (
    reg_wr && reg_addr == 5'h09 ##1 reg_rd && reg_addr == 5'h09 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("activate pattern readback wrong");
  a_manual_loop: assert property (
    (remote_loop_select & $past(remote_loop_select) & ~remote_loop_active) == 8'h00)
    else $error("manual loop not honoured");
  a_loop_path: assert property (
    (remote_loop_active[0] && $stable(rx_data[0]) && $stable(rx_clk[0])) [*5]
    |-> {line_tx_clk[0], line_tx_data[0]} == {rx_clk[0], rx_data[0]}) else $error("loop path wrong");
endmodule : ilc_top_properties

bind ilc_top ilc_top_properties #(.QUAL_CYCLES(QUAL_CYCLES)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .rx_clk(rx_clk), .rx_data(rx_data), .tx_clk(tx_clk), .tx_data(tx_data),
  .remote_loop_select(remote_loop_select), .line_tx_clk(line_tx_clk), .line_tx_data(line_tx_data),
  .code_presence_status(code_presence_status), .remote_loop_active(remote_loop_active));

// ===== verif/ilc_far_end.sv
// far-end line equipment: recovered clock and data on eight channels
// assumes ref_clk timing; one bit every 2*HALF cycles on all channels
`timescale 1ns/1ps

module ilc_far_end #(
  parameter int HALF = 6
) (
  input  wire logic       ref_clk, // clock
  input  wire logic       rst_n,   // reset
  input  wire logic [7:0] ch_en,   // channels sending
  input  wire logic [7:0] pat,     // code, msb first
  input  wire logic [3:0] len,     // code length
  input  wire logic       err,     // corrupt next bit
  output logic      [7:0] rx_clk,  // line clock
  output logic      [7:0] rx_data  // line data
);
  int   ph;
  int   idx;
  logic pend;

  // live span: clock never stops, idle channels carry zeros
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph      <= 0;
      idx     <= 0;
      pend    <= 1'b0;
      rx_clk  <= 8'h00;
      rx_data <= 8'h00;
    end else begin
      ph   <= (ph == HALF - 1) ? 0 : ph + 1;
      pend <= (pend | err) & !(ph == HALF - 1 && rx_clk[0]);
      if (ph == HALF - 1) begin
        rx_clk <= ~rx_clk;
        // data moves on the falling line clock, settled at the rising one
        if (rx_clk[0]) begin
          idx     <= (idx + 1) % len;                                   // code repeats
          rx_data <= ch_en & {8{pat[7 - (idx + 1) % len] ^ (pend | err)}}; // one bad bit
        end
      end
    end
  end
endmodule : ilc_far_end

// ===== verif/tb.sv
// self-checking bench for the inband loop code unit
// assumes a 200 MHz ref_clk and the far-end model on the receive lines
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
`define WAITC(c, n) for (int w = 0; w < (n) && !(c); w++) @(negedge ref_clk);

module tb;
  localparam int unsigned QUAL = 200; // shortened qualification time
  logic        ref_clk, rst_n, reg_wr, reg_rd, irq, err;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rx_clk, rx_data, tx_clk, tx_data, sel;
  logic [7:0]  lpres, lact, ltxc, ltxd, ch_en, pat, apat, dpat, m, rd_v;
  logic [3:0]  len;
  logic [15:0] bits;
  logic [4:0]  offs[5] = '{5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0F};
  int          mismatches, n_tests, lc, txc;

  ilc_top #(.QUAL_CYCLES(QUAL)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .rx_clk(rx_clk), .rx_data(rx_data), .tx_clk(tx_clk), .tx_data(tx_data), .remote_loop_select(sel),
    .line_tx_clk(ltxc), .line_tx_data(ltxd), .code_presence_status(lpres), .remote_loop_active(lact));
  ilc_far_end u_far (.ref_clk(ref_clk), .rst_n(rst_n), .ch_en(ch_en), .pat(pat), .len(len), .err(err),
    .rx_clk(rx_clk), .rx_data(rx_data));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // system transmit side: free clock, random data each bit
  always @(negedge ref_clk) begin
    txc <= (txc == 5) ? 0 : txc + 1;
    if (txc == 5) begin
      tx_clk <= ~tx_clk;
      if (tx_clk[0]) tx_data <= 8'($urandom);
    end
  end

  // ****************************************************************
  // host tasks, called at a falling edge, back to back allowed
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    // one idle edge first, so a second write never re-raises the strobe in the step that lowered it
    @(negedge ref_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    rd(a, rd_v);
    `CHK("register", e, rd_v)
  endtask : rc

  // samples channel 0 line data at each falling line clock, skipping settling bits
  task automatic grab(output logic [15:0] b);
    int   k;
    logic p;
    k = -4;
    p = 1'b0;
    b = 16'h0000;
    for (int c = 0; c < 1000 && k < 16; c++) begin
      @(posedge ref_clk);
      #1;
      if (p && !ltxc[0]) begin
        if (k >= 0) b[k] = ltxd[0];
        k++;
      end
      p = ltxc[0];
    end
    @(negedge ref_clk);
  endtask : grab

  function automatic logic [7:0] cfgb(input logic det, input logic aut, input int l);
    cfgb = {2'b00, det, aut, 2'(l), 2'(l)};
  endfunction : cfgb

  // true when the bits are the code repeated at some starting phase
  function automatic logic gen_ok(input logic [15:0] b, input logic [7:0] p, input int l);
    logic ok;
    gen_ok = 1'b0;
    for (int r = 0; r < l; r++) begin
      ok = 1'b1;
      for (int i = 0; i < 2 * l; i++) ok &= (b[i] === p[7 - (i + r) % l]);
      gen_ok |= ok;
    end
  endfunction : gen_ok

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hEAC50C78));
    {rst_n, reg_wr, reg_rd, err, reg_addr, reg_wdata, sel, ch_en, pat} = '0;
    {tx_clk, tx_data, txc, mismatches, n_tests} = '0;
    len = 4'h5;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    // register file: random bytes, reserved config bits read zero, refused writes
    foreach (offs[i]) begin
      apat = 8'($urandom);
      wr(offs[i], (offs[i] == 5'h08) ? apat & 8'hDF : apat);
      rc(offs[i], (offs[i] == 5'h08) ? apat & 8'h1F : apat);
    end
    wr(5'h0B, 8'hFF);
    rc(5'h0B, 8'h00);
    wr(5'h03, 8'h5A);
    rc(5'h03, 8'h00);
    $display("test registers done");
    // report-only detection; a leading one keeps codes off the all-zero idle line
    lc   = $urandom % 4;
    len  = 4'(5 + lc);
    apat = 8'($urandom) | 8'h80;
    dpat = apat ^ 8'h40;
    m    = 8'($urandom) | 8'h01;
    wr(5'h0F, 8'h00);
    wr(5'h09, apat);
    wr(5'h0A, dpat);
    wr(5'h0C, 8'hFF);
    rd(5'h0D, rd_v);
    wr(5'h08, cfgb(1'b1, 1'b0, lc));
    pat   = apat;
    ch_en = m;
    `WAITC(lpres === m, 400)
    @(negedge ref_clk); // irq is registered one cycle after the presence change
    `CHK("presence", m, lpres)
    `CHK("report only", 8'h00, lact)
    `CHK("irq", 1'b1, irq)
    rc(5'h0D, m);
    wr(5'h0C, 8'h00);
    ch_en = 8'h00;
    `WAITC(lpres === 8'h00, 250)
    repeat (4) @(negedge ref_clk);
    `CHK("masked irq", 1'b0, irq)
    rc(5'h0D, m);
    $display("test detection done");
    // detection off with auto set, then manual loop
    wr(5'h08, cfgb(1'b0, 1'b1, lc));
    ch_en = m;
    repeat (400) @(negedge ref_clk);
    `CHK("detect off", 8'h00, lpres | lact)
    sel = 8'($urandom);
    repeat (3) @(negedge ref_clk);
    `CHK("manual loop", sel, lact)
    sel = 8'h00;
    // auto loop in, then out with one corrupted bit restarting the count
    wr(5'h08, cfgb(1'b1, 1'b1, lc));
    `WAITC(lact === m, 600)
    `CHK("loop entered", m, lact)
    pat = dpat;
    // corrupt well before the deactivate count can finish, whatever the line phase
    repeat (100) @(negedge ref_clk);
    err = 1'b1;
    @(negedge ref_clk);
    err = 1'b0;
    repeat (200) @(negedge ref_clk);
    `CHK("count restart", m, lact)
    `WAITC(lact === 8'h00, 600)
    `CHK("loop left", 8'h00, lact)
    $display("test auto loop done");
    // generator, both codes
    wr(5'h08, cfgb(1'b0, 1'b0, lc));
    ch_en = 8'h00;
    for (int s = 0; s < 2; s++) begin
      wr(5'h0E, 8'(s));
      wr(5'h0F, m);
      grab(bits);
      `CHK("generated", 1'b1, gen_ok(bits, s ? dpat : apat, 5 + lc))
      wr(5'h0F, 8'h00);
    end
    $display("test generator done");
    wrap_up();
  end
endmodule : tb
